// file: rtl/nv_host_pkg.sv
`default_nettype none
package nv_host_pkg;

    // ==========================================================
    // Bus and counter widths, and the sampler depth.
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CNT_W = 20;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Timing figures in their own units and their cycle counts at 100 MHz.
    localparam int CLK_NS = 10;
    localparam int T_READ_NS = 70;
    localparam int T_WRITE_NS = 55;
    localparam int T_DATA_LEAD_NS = 30;
    localparam int T_SEQ_PULSE_NS = 60;
    localparam int T_RECALL_US = 20;
    localparam int T_STORE_MS = 10;
    localparam int T_RESTORE_US = 650;
    // Read waits also cover the two-stage sampler on the returned data.
    localparam int RD_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int WR_CYC = (T_WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam int LEAD_CYC = (T_DATA_LEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SEQ_CYC = (T_SEQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECALL_CYC = (T_RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int STORE_CYC_DEF = (T_STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int RESTORE_CYC_DEF = (T_RESTORE_US * 1000 + CLK_NS - 1) / CLK_NS;

    // ==========================================================
    // Sequence addresses; the top address bit is always driven low.
    localparam int SEQ_STEPS = 6;
    localparam logic [ADDR_W-1:0] SEQ_ADDR [0:4] = '{15'h0E38, 15'h31C7, 15'h03E0,
                                                     15'h3C1F, 15'h303F};
    localparam logic [ADDR_W-1:0] SAVE_ADDR = 15'h0FC0;
    localparam logic [ADDR_W-1:0] RELOAD_ADDR = 15'h0C63;

    // ==========================================================
    // Command codes of the user port.
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_SAVE = 2'h2,
        OP_RELOAD = 2'h3
    } op_t;

endpackage : nv_host_pkg
`default_nettype wire

// file: rtl/nv_sram_host.sv
`timescale 1ns/1ps
`default_nettype none
module nv_sram_host #(
    parameter int STORE_CYC = nv_host_pkg::STORE_CYC_DEF,
    parameter int RESTORE_CYC = nv_host_pkg::RESTORE_CYC_DEF
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_cmd_valid,
    input wire nv_host_pkg::op_t i_cmd_op,
    input wire logic [nv_host_pkg::ADDR_W-1:0] i_cmd_addr,
    input wire logic [nv_host_pkg::DATA_W-1:0] i_cmd_wdata,
    output logic o_cmd_ready,
    output logic o_rsp_valid,
    output logic [nv_host_pkg::DATA_W-1:0] o_rsp_rdata,
    input wire logic i_power_good,
    output logic [nv_host_pkg::ADDR_W-1:0] o_addr_bus,
    output logic o_chip_on_n,
    output logic o_output_drive_n,
    output logic o_load_strobe_n,
    output logic [nv_host_pkg::DATA_W-1:0] o_data_bus_out,
    output logic o_data_bus_oe,
    input wire logic [nv_host_pkg::DATA_W-1:0] i_data_bus_in
);
    import nv_host_pkg::*;

    // ==========================================================
    // State machine.
    typedef enum logic [6:0] {
        ST_PWR = 7'h01,
        ST_IDLE = 7'h02,
        ST_READ = 7'h04,
        ST_WRITE = 7'h08,
        ST_SEQ = 7'h10,
        ST_GAP = 7'h20,
        ST_NVWAIT = 7'h40
    } state_t;

    state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [2:0] step_reg, step_next;
    op_t op_reg, op_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
    logic [DATA_W-1:0] dout_reg, dout_next, rdata_reg, rdata_next;
    logic doe_reg, doe_next, ready_reg, ready_next, rsp_reg, rsp_next;
    logic pg_meta_reg, pg_sync_reg;
    logic [DATA_W-1:0] din_meta_reg, din_sync_reg;

    // ==========================================================
    // Pin samplers: power-good and returned data come from outside the clock.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pg_meta_reg <= 1'b0;
            pg_sync_reg <= 1'b0;
            din_meta_reg <= '0;
            din_sync_reg <= '0;
        end else begin
            pg_meta_reg <= i_power_good;
            pg_sync_reg <= pg_meta_reg;
            din_meta_reg <= i_data_bus_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // Decodes shared by the next-state logic.
    wire cnt_zero = (cnt_reg == '0);
    wire take = i_cmd_valid && ready_reg && pg_sync_reg;
    wire last_step = (step_reg == 3'(SEQ_STEPS - 1));
    // The sixth address alone picks save or reload.
    wire [ADDR_W-1:0] seq_addr = !last_step ? SEQ_ADDR[step_reg] :
                                 (op_reg == OP_SAVE) ? SAVE_ADDR : RELOAD_ADDR;
    wire [CNT_W-1:0] nv_wait = (op_reg == OP_SAVE) ? CNT_W'(STORE_CYC - 1) :
                                                     CNT_W'(RECALL_CYC - 1);

    // ==========================================================
    // Next-state logic. Only one access runs at a time, so a sequence is never
    // interrupted by another access once started.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
        step_next = step_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        ce_n_next = ce_n_reg;
        oe_n_next = oe_n_reg;
        we_n_next = we_n_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        rdata_next = rdata_reg;
        rsp_next = 1'b0;
        unique case (state_reg)
            ST_PWR: begin
                // Strobes stay high while power is bad and through the reload.
                ce_n_next = 1'b1;
                oe_n_next = 1'b1;
                we_n_next = 1'b1;
                doe_next = 1'b0;
                if (!pg_sync_reg) begin
                    cnt_next = CNT_W'(RESTORE_CYC - 1);
                end else if (cnt_zero) begin
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (!pg_sync_reg) begin
                    // No new access after the supply has dropped.
                    state_next = ST_PWR;
                    cnt_next = CNT_W'(RESTORE_CYC - 1);
                end else if (take) begin
                    op_next = i_cmd_op;
                    ce_n_next = 1'b0;
                    unique case (i_cmd_op)
                        OP_READ: begin
                            state_next = ST_READ;
                            addr_next = i_cmd_addr;
                            oe_n_next = 1'b0;
                            cnt_next = CNT_W'(RD_CYC - 1);
                        end
                        OP_WRITE: begin
                            // Data is driven from the first cycle, well ahead of the end.
                            state_next = ST_WRITE;
                            addr_next = i_cmd_addr;
                            we_n_next = 1'b0;
                            dout_next = i_cmd_wdata;
                            doe_next = 1'b1;
                            cnt_next = CNT_W'(WR_CYC - 1);
                        end
                        OP_SAVE, OP_RELOAD: begin
                            // Save and reload both start with the first step.
                            state_next = ST_SEQ;
                            step_next = 3'h0;
                            addr_next = SEQ_ADDR[0];
                            cnt_next = CNT_W'(SEQ_CYC - 1);
                        end
                    endcase
                end
            end
            ST_READ: begin
                if (cnt_zero) begin
                    rdata_next = din_sync_reg;
                    rsp_next = 1'b1;
                    ce_n_next = 1'b1;
                    oe_n_next = 1'b1;
                    state_next = ST_GAP;
                end
            end
            ST_WRITE: begin
                if (cnt_zero) begin
                    // Both strobes rise together; address and data stay one more cycle.
                    ce_n_next = 1'b1;
                    we_n_next = 1'b1;
                    rsp_next = 1'b1;
                    state_next = ST_GAP;
                end
            end
            ST_SEQ: begin
                if (ce_n_reg) begin
                    // Next chip_on_n pulse with load_strobe_n high.
                    addr_next = seq_addr;
                    ce_n_next = 1'b0;
                    cnt_next = CNT_W'(SEQ_CYC - 1);
                end else if (cnt_zero) begin
                    ce_n_next = 1'b1;
                    if (last_step) begin
                        state_next = ST_NVWAIT;
                        cnt_next = nv_wait;
                    end else begin
                        step_next = step_reg + 3'h1;
                    end
                end
            end
            ST_GAP: begin
                doe_next = 1'b0;
                state_next = ST_IDLE;
            end
            ST_NVWAIT: begin
                // The device ignores the bus until its cycle time has passed.
                if (cnt_zero) begin
                    rsp_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_PWR;
            end
        endcase
        // Save and reload are refused while power is bad.
        ready_next = (state_next == ST_IDLE) && pg_sync_reg;
    end

    // ==========================================================
    // State registers; power-up starts in the restore wait.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= ST_PWR;
            cnt_reg <= CNT_W'(RESTORE_CYC - 1);
            step_reg <= 3'h0;
            op_reg <= OP_READ;
            addr_reg <= '0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dout_reg <= '0;
            doe_reg <= 1'b0;
            rdata_reg <= '0;
            ready_reg <= 1'b0;
            rsp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            step_reg <= step_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            ce_n_reg <= ce_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            rsp_reg <= rsp_next;
        end
    end

    // Pins and user answers straight from flip-flops.
    assign o_addr_bus = addr_reg;
    assign o_chip_on_n = ce_n_reg;
    assign o_output_drive_n = oe_n_reg;
    assign o_load_strobe_n = we_n_reg;
    assign o_data_bus_out = dout_reg;
    assign o_data_bus_oe = doe_reg;
    assign o_cmd_ready = ready_reg;
    assign o_rsp_valid = rsp_reg;
    assign o_rsp_rdata = rdata_reg;

    // ==========================================================
    // Checks on what this controller drives.
    a_write_oe_high: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        !we_n_reg |-> oe_n_reg && doe_reg && !ce_n_reg)
        else $error("output drive low or data released during write");
    a_write_pulse_len: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $fell(we_n_reg) |-> !we_n_reg [*6] ##1 we_n_reg)
        else $error("write pulse not six cycles");
    a_write_addr_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(we_n_reg) |-> $stable(addr_reg) && doe_reg && $stable(dout_reg))
        else $error("address or data moved at write end");
    a_write_data_lead: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(we_n_reg) |-> $past(doe_reg, 3) && $past(dout_reg, 3) == dout_reg)
        else $error("write data not set up three cycles ahead");
    a_powerdown_quiet: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (state_reg == ST_PWR) |-> we_n_reg && ce_n_reg)
        else $error("strobe active during power wait");
    a_seq_pulse_len: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (state_reg == ST_SEQ) && $fell(ce_n_reg) |-> (!ce_n_reg && we_n_reg) [*6] ##1 ce_n_reg)
        else $error("sequence pulse wrong");
    a_nv_bus_idle: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (state_reg == ST_NVWAIT) |-> ce_n_reg && we_n_reg && !doe_reg && !ready_reg)
        else $error("bus active during non-volatile cycle");
    a_save_power_ok: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (state_reg == ST_IDLE) && !pg_sync_reg |=> (state_reg == ST_PWR) && !ready_reg)
        else $error("command still possible while power bad");
    a_take_busy: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        take |=> (state_reg != ST_IDLE) && !ready_reg)
        else $error("ready stayed high after a command was taken");
    a_read_resp: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $fell(ce_n_reg) && !oe_n_next && (state_next == ST_READ) |=> !ce_n_reg [*8] ##1 rsp_reg)
        else $error("read answer not after nine cycles");
    a_seq_last_addr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        $rose(state_reg == ST_NVWAIT) |-> addr_reg == ((op_reg == OP_SAVE) ? SAVE_ADDR :
                                                       RELOAD_ADDR))
        else $error("sixth address does not match operation");

endmodule : nv_sram_host
`default_nettype wire

// file: test/nv_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Behavioural byte-wide memory with a non-volatile copy and sequence detector.
module nv_sram_model #(
    parameter int SAVE_NS = 150,
    parameter int RELOAD_NS = 100
) (
    input wire logic [14:0] i_addr,
    input wire logic i_chip_on_n,
    input wire logic i_output_drive_n,
    input wire logic i_load_strobe_n,
    input wire logic i_power_good,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq
);
    import nv_host_pkg::*;
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [7:0] last = 8'h00;
    bit busy = 0;
    bit dirty = 0;
    bit wr_act = 0;
    bit rd_ok = 0;
    bit ce_q = 1;
    int step = 0;
    event save_ev;
    event reload_ev;
    wire logic drv = !busy && !i_chip_on_n && !i_output_drive_n &&
                     i_load_strobe_n;

    // Both arrays start cleared so the bench can predict untouched bytes.
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        nv = mem;
    end

    // Released lines show the inverse of the last byte, so a late sample is caught.
    assign o_dq = drv ? mem[i_addr] : ~last;
    always @* if (drv) last = mem[i_addr];

    // Write capture at the ending strobe edge; a pulse with a write is no sequence step.
    always @(i_chip_on_n or i_load_strobe_n) begin
        if (!i_chip_on_n && ce_q) rd_ok = i_load_strobe_n;
        if (!i_chip_on_n && !i_load_strobe_n) rd_ok = 0;
        if (wr_act && (i_chip_on_n || i_load_strobe_n)) begin
            mem[i_addr] = i_dq;
            dirty = 1;
            step = 0;
        end else if (i_chip_on_n && !ce_q && !busy && rd_ok) begin
            if (step < 5 && i_addr[13:0] == SEQ_ADDR[step][13:0]) step++;
            else if (step == 5 && i_addr[13:0] == SAVE_ADDR[13:0]) begin
                step = 0;
                if (i_power_good) -> save_ev;
            end else if (step == 5 && i_addr[13:0] == RELOAD_ADDR[13:0]) begin
                step = 0;
                -> reload_ev;
            end else step = (i_addr[13:0] == SEQ_ADDR[0][13:0]) ? 1 : 0;
        end
        ce_q = i_chip_on_n;
        wr_act = !busy && i_power_good && !i_chip_on_n && !i_load_strobe_n;
    end

    // Save cycle: pins are dead until the copy lands.
    always @(save_ev) begin
        busy = 1;
        #(SAVE_NS);
        nv = mem;
        dirty = 0;
        busy = 0;
    end

    // Reload cycle: clear first, then copy; the non-volatile side is untouched.
    always @(reload_ev) begin
        busy = 1;
        foreach (mem[i]) mem[i] = 8'h00;
        #(RELOAD_NS);
        mem = nv;
        dirty = 0;
        busy = 0;
    end

    // Power-good edges request the automatic save and reload.
    // The dirty flag is looked at only after the grace time, so a write that was
    // still running when the supply dropped is saved as well.
    always @(negedge i_power_good) begin
        #150;
        if (dirty) -> save_ev;
    end
    always @(posedge i_power_good) -> reload_ev;
endmodule : nv_sram_model
`default_nettype wire

// file: test/test_nv_sram_host.sv
`timescale 1ns/1ps
`default_nettype none
module test_nv_sram_host;
    import nv_host_pkg::*;
    typedef struct {bit rd; logic [7:0] d;} note_t;
    logic i_core_clk = 0;
    logic i_nrst = 0;
    logic i_cmd_valid = 0;
    op_t i_cmd_op = OP_READ;
    logic [14:0] i_cmd_addr = '0;
    logic [7:0] i_cmd_wdata = '0;
    logic i_power_good = 0;
    logic o_cmd_ready, o_rsp_valid, o_chip_on_n, o_output_drive_n, o_load_strobe_n;
    logic o_data_bus_oe;
    logic [7:0] o_rsp_rdata, o_data_bus_out, dev_dq;
    logic [14:0] o_addr_bus;
    wire logic [7:0] bus = o_data_bus_oe ? o_data_bus_out : dev_dq;
    int miscompares = 0;
    int num_checks = 0;
    note_t notes[$];
    logic [7:0] sh_ram [0:32767];
    logic [7:0] sh_nv [0:32767];

    // ==========================================================
    // Design, device model and clock. Short counts keep the run brief.
    nv_sram_host #(.STORE_CYC(20), .RESTORE_CYC(20)) DUT (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
        .i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata), .o_cmd_ready(o_cmd_ready),
        .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .i_power_good(i_power_good),
        .o_addr_bus(o_addr_bus), .o_chip_on_n(o_chip_on_n),
        .o_output_drive_n(o_output_drive_n), .o_load_strobe_n(o_load_strobe_n),
        .o_data_bus_out(o_data_bus_out), .o_data_bus_oe(o_data_bus_oe),
        .i_data_bus_in(bus));
    nv_sram_model dev (.i_addr(o_addr_bus), .i_chip_on_n(o_chip_on_n),
        .i_output_drive_n(o_output_drive_n), .i_load_strobe_n(o_load_strobe_n),
        .i_power_good(i_power_good), .i_dq(bus), .o_dq(dev_dq));
    always #5 i_core_clk = ~i_core_clk;

    // ==========================================================
    // Checking and closing.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: read %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // Each response takes the oldest note; only reads carry a value to compare.
    always @(posedge i_core_clk) begin
        if (o_rsp_valid === 1'b1) begin
            if (notes.size() == 0) check(8'hxx, 8'h00);
            else if (notes[0].rd) check(o_rsp_rdata, notes.pop_front().d);
            else void'(notes.pop_front());
        end
    end

    // Issue one command, holding it until the edge where ready is seen high.
    task automatic cmd(input op_t op, input logic [14:0] a, input logic [7:0] d, input bit chk);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_cmd_valid <= 1'b1;
        i_cmd_op <= op;
        i_cmd_addr <= a;
        i_cmd_wdata <= d;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_cmd_ready !== 1'b1 && n < 5000);
        if (n >= 5000) miscompares++;
        notes.push_back('{chk && op == OP_READ, sh_ram[a]});
        i_cmd_valid <= 1'b0;
        if (op == OP_WRITE) sh_ram[a] = d;
    endtask : cmd

    // Five leading sequence reads, then the selecting read, left unchecked.
    task automatic seq(input logic [14:0] last_a, input bit top);
        for (int k = 0; k < 5; k++) begin
            cmd(OP_READ, SEQ_ADDR[k] | {top, 14'h0000}, 8'h00, 1);
        end
        cmd(OP_READ, last_a, 8'h00, 0);
        repeat (150) @(posedge i_core_clk);
    endtask : seq

    // ==========================================================
    // Scenarios.
    initial begin
        logic [14:0] a [8];
        void'($urandom(32'h10c0));
        foreach (sh_ram[i]) sh_ram[i] = 8'h00;
        sh_nv = sh_ram;
        repeat (16) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        i_power_good <= 1'b1;
        // Random writes, then reads back.
        foreach (a[k]) a[k] = 15'($urandom_range(32767));
        foreach (a[k]) cmd(OP_WRITE, a[k], 8'($urandom), 0);
        foreach (a[k]) cmd(OP_READ, a[k], 8'h00, 1);
        // Software save, overwrite, software reload restores the saved byte.
        cmd(OP_SAVE, '0, '0, 0);
        sh_nv = sh_ram;
        cmd(OP_WRITE, a[0], ~sh_ram[a[0]], 0);
        cmd(OP_RELOAD, '0, '0, 0);
        sh_ram = sh_nv;
        cmd(OP_READ, a[0], 8'h00, 1);
        // A write between steps aborts the sequence, so no reload follows.
        cmd(OP_READ, SEQ_ADDR[0], 8'h00, 1);
        cmd(OP_READ, SEQ_ADDR[1], 8'h00, 1);
        cmd(OP_WRITE, 15'h0100, ~sh_nv[15'h0100], 0);
        for (int k = 2; k < 5; k++) cmd(OP_READ, SEQ_ADDR[k], 8'h00, 1);
        cmd(OP_READ, RELOAD_ADDR, 8'h00, 1);
        cmd(OP_READ, 15'h0100, 8'h00, 1);
        // A repeated first step restarts; top address bit set is still matched.
        cmd(OP_WRITE, 15'h0200, ~sh_nv[15'h0200], 0);
        cmd(OP_READ, SEQ_ADDR[0], 8'h00, 1);
        seq(RELOAD_ADDR | 15'h4000, 1);
        sh_ram = sh_nv;
        cmd(OP_READ, 15'h0200, 8'h00, 1);
        // Power drops during a write: it completes, is saved, and reloads on return.
        cmd(OP_WRITE, 15'h0300, ~sh_ram[15'h0300], 0);
        repeat (3) @(posedge i_core_clk);
        i_power_good <= 1'b0;
        repeat (100) @(posedge i_core_clk);
        i_power_good <= 1'b1;
        sh_nv = sh_ram;
        cmd(OP_READ, 15'h0300, 8'h00, 1);
        cmd(OP_READ, a[1], 8'h00, 1);
        repeat (20) @(posedge i_core_clk);
        // Every note must have met its answer by now.
        check(8'(notes.size()), 8'h00);
        end_sim();
    end

    // Watchdog well beyond the expected run of some three thousand cycles.
    initial begin
        repeat (30000) @(posedge i_core_clk);
        miscompares++;
        end_sim();
    end
endmodule : test_nv_sram_host
`default_nettype wire
